// ==== verilog/irq_ctrl_pkg.sv ====
/*
 * Constants and carrier types shared by the priority interrupt controller.
 * Assumes one clock domain, a 20 MHz CPU clock and six clocks per machine cycle.
 */
package irq_ctrl_pkg;

	// ****************************************************************
	// Counts and sizes
	// ****************************************************************
	localparam int        NUM_SOURCES          = 13;   // Interrupt sources
	localparam int        NUM_LEVELS           = 4;    // Priority levels
	localparam int        CLK_PERIOD_NS        = 50;   // CPU clock period
	localparam int        MACHINE_CYCLE_CLOCKS = 6;    // CPU clocks per machine cycle
	localparam logic [2:0] MC_LAST             = 3'(MACHINE_CYCLE_CLOCKS - 1);
	localparam logic [2:0] MC_RESET            = 3'h0; // Machine cycle counter at reset
	localparam int        GLOBAL_ENABLE_BIT    = 7;    // Global enable in enable reg a

	// ****************************************************************
	// Source indices, in table order
	// ****************************************************************
	localparam logic [3:0] SRC_EXT0      = 4'h0;
	localparam logic [3:0] SRC_TIMER0    = 4'h1;
	localparam logic [3:0] SRC_EXT1      = 4'h2;
	localparam logic [3:0] SRC_TIMER1    = 4'h3;
	localparam logic [3:0] SRC_SERIAL    = 4'h4;
	localparam logic [3:0] SRC_BROWNOUT  = 4'h5;
	localparam logic [3:0] SRC_BUS       = 4'h6;
	localparam logic [3:0] SRC_KEYPAD    = 4'h7;
	localparam logic [3:0] SRC_COMP2     = 4'h8;
	localparam logic [3:0] SRC_WATCHDOG  = 4'h9;
	localparam logic [3:0] SRC_CONVERTER = 4'hA;
	localparam logic [3:0] SRC_COMP1     = 4'hB;
	localparam logic [3:0] SRC_BUS_TIMER = 4'hC;

	// ****************************************************************
	// Per-source tables, index 0 first
	// ****************************************************************
	// Register holding enable and priority bits: 0 = reg a, 1 = reg b
	localparam logic [12:0] SRC_IN_REG_B = 13'h1DC0;
	// Bit position inside that register
	localparam logic [2:0] SRC_BIT [NUM_SOURCES] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4,
		3'h5, 3'h0, 3'h1, 3'h2, 3'h6, 3'h4, 3'h5, 3'h7};
	// Tie-break rank, 1 highest
	localparam logic [3:0] SRC_RANK [NUM_SOURCES] = '{4'h1, 4'h4, 4'h7, 4'hA, 4'hC,
		4'h2, 4'h5, 4'h8, 4'hB, 4'h3, 4'h6, 4'h9, 4'hD};
	// Fixed vector addresses
	localparam logic [15:0] SRC_VECTOR [NUM_SOURCES] = '{16'h0003, 16'h000B, 16'h0013,
		16'h001B, 16'h0023, 16'h002B, 16'h0033, 16'h003B, 16'h0043, 16'h0053,
		16'h005B, 16'h0063, 16'h0073};
	// Sources able to end power down
	localparam logic [12:0] WAKE_MASK = 13'h0FA5;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	// Priority configuration registers
	typedef struct packed {
		logic [7:0] prio_high_reg_b;
		logic [7:0] prio_low_reg_b;
		logic [7:0] prio_high_reg_a;
		logic [7:0] prio_low_reg_a;
	} prio_regs_s;

	// Per-source priority levels
	typedef logic [NUM_SOURCES-1:0][1:0] level_vec_t;

endpackage

// ==== verilog/ext_request_unit.sv ====
/*
 * One external request input: machine-cycle sampling, level or falling-edge trigger.
 * Assumes the sample strobe pulses for one clock once per machine cycle.
 */
`timescale 1ns/1ns
module ext_request_unit
(
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_reset_n,
	// Control
	input  wire logic i_sample,          // Machine cycle strobe
	input  wire logic i_trigger_select,  // 0 level, 1 falling edge
	input  wire logic i_vector_taken,    // CPU branched to this source
	// Pin and flag
	input  wire logic i_ext_request_pin_n,
	output logic      o_request_flag
);

	// ****************************************************************
	// Pin sampling
	// ****************************************************************
	logic pin_sample;   // Latest machine-cycle sample

	// Sample once per machine cycle; idle high
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pin_sample  <= 1'b1;
		end
		else if (i_sample)
		begin
			pin_sample  <= i_ext_request_pin_n;
		end
	end

	logic edge_seen;    // High sample then low sample
	assign edge_seen = i_sample && pin_sample && !i_ext_request_pin_n;

	// ****************************************************************
	// Request flag
	// ****************************************************************
	// Level mode tracks the sampled pin; edge mode is sticky, set beats clear
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_request_flag <= 1'b0;
		else if (!i_trigger_select)
		begin
			if (i_sample)
				o_request_flag <= !i_ext_request_pin_n;
		end
		else if (edge_seen)
			o_request_flag <= 1'b1;
		else if (i_vector_taken)
			o_request_flag <= 1'b0;
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_edge_sets_flag: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_trigger_select && edge_seen |=> o_request_flag)
		else $error("edge flag not set after high-low samples");
	a_level_follows_pin: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!i_trigger_select && i_sample |=> o_request_flag == !pin_sample)
		else $error("level flag does not follow sampled pin");
	a_edge_auto_clear: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_trigger_select && i_vector_taken && !edge_seen |=> !o_request_flag)
		else $error("edge flag not cleared on vector");
	c_edge_event: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_trigger_select && edge_seen);

endmodule

// ==== verilog/priority_select.sv ====
/*
 * Combinational winner selection among pending sources by level, then rank.
 * Assumes pending already carries enable and global masking.
 */
`timescale 1ns/1ns
module priority_select
(
	// Requests
	input  wire logic [12:0]                   i_pending,
	input  wire irq_ctrl_pkg::level_vec_t       i_levels,
	input  wire logic [3:0]                    i_active,   // Levels in service
	// Winner
	output logic                               o_valid,
	output logic [3:0]                         o_index,
	output logic [1:0]                         o_level
);

	// Sort key: level above inverted rank
	function automatic logic [5:0] sort_key(input logic [1:0] lvl, input logic [3:0] rank);
		sort_key = {lvl, 4'hF - rank};
	endfunction

	// Scan all sources, keep the best key
	always_comb
	begin
		logic [5:0] best;
		best    = 6'h00;
		o_valid = 1'b0;
		o_index = 4'h0;
		for (int i = 0; i < irq_ctrl_pkg::NUM_SOURCES; i++)
		begin
			if (i_pending[i] && (!o_valid ||
				sort_key(i_levels[i], irq_ctrl_pkg::SRC_RANK[i]) > best))
			begin
				best    = sort_key(i_levels[i], irq_ctrl_pkg::SRC_RANK[i]);
				o_valid = 1'b1;
				o_index = 4'(i);
			end
		end
		o_level = best[5:4];
		// Only a strictly higher level than any in service may preempt
		for (int l = 0; l < irq_ctrl_pkg::NUM_LEVELS; l++)
		begin
			if (i_active[l] && 2'(l) >= o_level)
				o_valid = 1'b0;
		end
	end

endmodule

// ==== verilog/priority_interrupt_controller.sv ====
/*
 * Four-level priority interrupt controller for thirteen sources, with two
 * external request pins, fixed vectors and power-down wake.
 * Assumes the CPU pulses i_irq_taken when it branches to the presented
 * vector and i_irq_return when a service routine ends; all inputs are
 * synchronous to i_ref_clk.
 */
// Overview of operation
// - Thirteen sources, each one of four levels
// - Per-source enables; global bit masks all
// - Level from low and high priority bits
// - Only strictly higher level preempts running routine
// - Higher level wins simultaneous requests
// - Fixed rank 1 to 13 breaks ties
// - Fixed vector per source, on an eight-byte grid, two slots unused
// - Serial: tx or rx, vector 0023h, rank 12
// - Only wake-capable sources end power down
// - Trigger select zero: low level requests
// - Edge mode: high sample then low sets
// - Pins sampled once per six-clock machine cycle
// - Edge flag clears when routine is entered
// - Level flag tracks pin, re-requests if low
// - Enabled external request wakes idle or power down
`timescale 1ns/1ns
module priority_interrupt_controller
(
	// Clock and reset
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_reset_n,
	// Enable and priority configuration
	input  wire logic [7:0]                i_irq_enable_reg_a,
	input  wire logic [7:0]                i_irq_enable_reg_b,
	input  wire irq_ctrl_pkg::prio_regs_s  i_prio,
	input  wire logic                      i_ext0_trigger_select,
	input  wire logic                      i_ext1_trigger_select,
	// External request pins, active low
	input  wire logic                      i_ext0_request_pin_n,
	input  wire logic                      i_ext1_request_pin_n,
	// Peripheral request flags
	input  wire logic                      i_timer_zero_overflow_flag,
	input  wire logic                      i_timer_one_overflow_flag,
	input  wire logic                      i_serial_tx_done_flag,
	input  wire logic                      i_serial_rx_done_flag,
	input  wire logic                      i_brownout_flag,
	input  wire logic                      i_bus_attention_flag,
	input  wire logic                      i_keypad_flag,
	input  wire logic                      i_comparator_two_flag,
	input  wire logic                      i_watchdog_overflow_flag,
	input  wire logic                      i_converter_done_flag,
	input  wire logic                      i_comparator_one_flag,
	input  wire logic                      i_bus_timeout_flag,
	// CPU side
	input  wire logic                      i_irq_taken,    // Vector accepted, one pulse
	input  wire logic                      i_irq_return,   // Routine ended, one pulse
	input  wire logic                      i_idle_mode,
	input  wire logic                      i_power_down_mode,
	output logic                           o_irq_request,
	output logic [15:0]                    o_vector_addr,
	output logic [1:0]                     o_irq_level,
	output logic [3:0]                     o_active_levels,
	output logic                           o_wake,
	// External request flags
	output logic                           o_ext0_request_flag,
	output logic                           o_ext1_request_flag
);

	// ****************************************************************
	// Machine cycle strobe
	// ****************************************************************
	logic [2:0] mc_count;   // Clock within machine cycle
	logic       mc_sample;  // One clock per machine cycle

	// Divide the CPU clock by six
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			mc_count <= irq_ctrl_pkg::MC_RESET;
		else if (mc_count == irq_ctrl_pkg::MC_LAST)
			mc_count <= irq_ctrl_pkg::MC_RESET;
		else
			mc_count <= mc_count + 3'h1;
	end

	assign mc_sample = (mc_count == irq_ctrl_pkg::MC_LAST);

	// ****************************************************************
	// External request units
	// ****************************************************************
	logic [3:0] taken_index;  // Source of the presented vector
	logic       ext0_taken;   // CPU enters external 0 routine
	logic       ext1_taken;   // CPU enters external 1 routine

	assign ext0_taken = i_irq_taken && o_irq_request && taken_index == irq_ctrl_pkg::SRC_EXT0;
	assign ext1_taken = i_irq_taken && o_irq_request && taken_index == irq_ctrl_pkg::SRC_EXT1;

	// External request 0
	ext_request_unit u_ext0
	(
		.i_ref_clk           (i_ref_clk),
		.i_reset_n           (i_reset_n),
		.i_sample            (mc_sample),
		.i_trigger_select    (i_ext0_trigger_select),
		.i_vector_taken      (ext0_taken),
		.i_ext_request_pin_n (i_ext0_request_pin_n),
		.o_request_flag      (o_ext0_request_flag)
	);

	// External request 1
	ext_request_unit u_ext1
	(
		.i_ref_clk           (i_ref_clk),
		.i_reset_n           (i_reset_n),
		.i_sample            (mc_sample),
		.i_trigger_select    (i_ext1_trigger_select),
		.i_vector_taken      (ext1_taken),
		.i_ext_request_pin_n (i_ext1_request_pin_n),
		.o_request_flag      (o_ext1_request_flag)
	);

	// ****************************************************************
	// Source gathering and masking
	// ****************************************************************
	logic [12:0]              src_flags;  // Raw request per source
	logic [12:0]              src_enable; // Per-source enable bit
	logic [12:0]              pending;    // Enabled, globally allowed
	irq_ctrl_pkg::level_vec_t src_levels; // Level per source

	// Pick one bit of reg a or reg b for a source
	function automatic logic pick_bit(input logic [7:0] reg_a, input logic [7:0] reg_b,
		input int idx);
		pick_bit = irq_ctrl_pkg::SRC_IN_REG_B[idx] ? reg_b[irq_ctrl_pkg::SRC_BIT[idx]]
			: reg_a[irq_ctrl_pkg::SRC_BIT[idx]];
	endfunction

	// Flags in source order
	always_comb
	begin
		src_flags                               = 13'h0000;
		src_flags[irq_ctrl_pkg::SRC_EXT0]       = o_ext0_request_flag;
		src_flags[irq_ctrl_pkg::SRC_TIMER0]     = i_timer_zero_overflow_flag;
		src_flags[irq_ctrl_pkg::SRC_EXT1]       = o_ext1_request_flag;
		src_flags[irq_ctrl_pkg::SRC_TIMER1]     = i_timer_one_overflow_flag;
		src_flags[irq_ctrl_pkg::SRC_SERIAL]     = i_serial_tx_done_flag || i_serial_rx_done_flag;
		src_flags[irq_ctrl_pkg::SRC_BROWNOUT]   = i_brownout_flag;
		src_flags[irq_ctrl_pkg::SRC_BUS]        = i_bus_attention_flag;
		src_flags[irq_ctrl_pkg::SRC_KEYPAD]     = i_keypad_flag;
		src_flags[irq_ctrl_pkg::SRC_COMP2]      = i_comparator_two_flag;
		src_flags[irq_ctrl_pkg::SRC_WATCHDOG]   = i_watchdog_overflow_flag;
		src_flags[irq_ctrl_pkg::SRC_CONVERTER]  = i_converter_done_flag;
		src_flags[irq_ctrl_pkg::SRC_COMP1]      = i_comparator_one_flag;
		src_flags[irq_ctrl_pkg::SRC_BUS_TIMER]  = i_bus_timeout_flag;
	end

	// Enable and level lookup for every source
	generate
		for (genvar s = 0; s < irq_ctrl_pkg::NUM_SOURCES; s++)
		begin : g_src
			assign src_enable[s] = pick_bit(i_irq_enable_reg_a, i_irq_enable_reg_b, s);
			assign src_levels[s] = {pick_bit(i_prio.prio_high_reg_a, i_prio.prio_high_reg_b, s),
				pick_bit(i_prio.prio_low_reg_a, i_prio.prio_low_reg_b, s)};
		end
	endgenerate

	assign pending = src_flags & src_enable
		& {13{i_irq_enable_reg_a[irq_ctrl_pkg::GLOBAL_ENABLE_BIT]}};

	// ****************************************************************
	// Arbitration
	// ****************************************************************
	logic       win_valid;  // A source may be presented
	logic [3:0] win_index;  // Winning source
	logic [1:0] win_level;  // Its level

	// Level first, then rank, then in-service ceiling
	priority_select u_select
	(
		.i_pending (pending),
		.i_levels  (src_levels),
		.i_active  (o_active_levels),
		.o_valid   (win_valid),
		.o_index   (win_index),
		.o_level   (win_level)
	);

	// ****************************************************************
	// Request presented to the CPU
	// ****************************************************************
	// Register the winner; drop it for the cycle after a take
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_irq_request <= 1'b0;
			o_vector_addr <= 16'h0000;
			o_irq_level   <= 2'h0;
			taken_index   <= 4'h0;
		end
		else
		begin
			o_irq_request <= win_valid && !i_irq_taken;
			o_vector_addr <= irq_ctrl_pkg::SRC_VECTOR[win_index];
			o_irq_level   <= win_level;
			taken_index   <= win_index;
		end
	end

	// ****************************************************************
	// Levels in service
	// ****************************************************************
	logic [3:0] top_active;  // Highest level in service, one-hot

	// Isolate the highest set bit
	always_comb
	begin
		top_active = 4'h0;
		for (int l = 0; l < irq_ctrl_pkg::NUM_LEVELS; l++)
		begin
			if (o_active_levels[l])
				top_active = 4'h1 << l;
		end
	end

	// Return ends the innermost routine, take opens a new one
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_active_levels <= 4'h0;
		else
		begin
			if (i_irq_taken && o_irq_request)
				o_active_levels <= (o_active_levels & ~(i_irq_return ? top_active : 4'h0))
					| (4'h1 << o_irq_level);
			else if (i_irq_return)
				o_active_levels <= o_active_levels & ~top_active;
		end
	end

	// ****************************************************************
	// Wake from idle and power down
	// ****************************************************************
	// Power down needs a wake-capable source; idle takes any enabled one
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_wake <= 1'b0;
		else
			o_wake <= (i_power_down_mode && |(pending & irq_ctrl_pkg::WAKE_MASK))
				|| (i_idle_mode && |pending);
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_sample_spacing: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		mc_sample |=> !mc_sample [*5] ##1 mc_sample)
		else $error("pin sample not once per six clocks");
	a_global_mask: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!i_irq_enable_reg_a[irq_ctrl_pkg::GLOBAL_ENABLE_BIT] |=> !o_irq_request)
		else $error("request raised with global enable clear");
	a_top_level_holds: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_active_levels[3] |=> !o_irq_request)
		else $error("top level routine preempted");
	a_no_same_level: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_irq_request |-> !o_active_levels[o_irq_level])
		else $error("request at a level already in service");
	a_vector_slot: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_irq_request |-> o_vector_addr[2:0] == 3'h3 && o_vector_addr <= 16'h0073)
		else $error("vector off the eight byte grid");
	a_serial_vector: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_irq_request && o_vector_addr == 16'h0023
			|-> $past(i_serial_tx_done_flag || i_serial_rx_done_flag))
		else $error("serial vector without tx or rx flag");
	a_wake_source: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		$rose(o_wake) |-> $past(i_idle_mode || |(pending & irq_ctrl_pkg::WAKE_MASK)))
		else $error("wake from a source that cannot wake");
	a_take_drops_req: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_irq_taken && o_irq_request |=> !o_irq_request)
		else $error("request held across a take");

	// Wake, nesting and external request checks
	a_pd_no_wake: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_power_down_mode && !i_idle_mode && !(|(pending & irq_ctrl_pkg::WAKE_MASK)) |=> !o_wake)
		else $error("power down woken by a source that cannot wake");
	a_idle_wake: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_idle_mode && |pending |=> o_wake)
		else $error("idle not woken by an enabled request");
	a_take_sets_level: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_irq_taken && o_irq_request |=> o_active_levels[$past(o_irq_level)])
		else $error("taken level not marked in service");
	a_ext0_raises_req: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_ext0_request_flag && i_irq_enable_reg_a[0]
			&& i_irq_enable_reg_a[irq_ctrl_pkg::GLOBAL_ENABLE_BIT]
			&& o_active_levels == 4'h0 && !i_irq_taken |=> o_irq_request)
		else $error("enabled external request not presented");

	c_preempt: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_irq_request && |o_active_levels);
	c_wake_power_down: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_wake && i_power_down_mode);
	c_nested_return: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_irq_return && $countones(o_active_levels) > 1);
	c_idle_wake: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_wake && i_idle_mode);

endmodule

// ==== tb/ext_pin_source.sv ====
/*
 * Model of an outside source on one active-low request pin.
 * Assumes the bench holds i_hold for a level request, pulses it for an edge.
 */
`timescale 1ns/1ns
module ext_pin_source
(
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_reset_n,
	// Command
	input  wire logic i_edge_mode,  // 1 falling edge, 0 low level
	input  wire logic i_hold,       // Level: hold low; edge: start
	// Pin
	output logic      o_pin_n
);
	logic [4:0] cnt;  // Edge sequence countdown

	// Edge sequence: twelve clocks high, then twelve clocks low
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			cnt <= 5'h0;
		else if (i_hold && cnt == 5'h0)
			cnt <= 5'h18;
		else if (cnt != 5'h0)
			cnt <= cnt - 5'h1;
	end

	// Pulled up when not requesting
	assign o_pin_n = i_edge_mode ? !(cnt != 5'h0 && cnt <= 5'hC) : !i_hold;
endmodule

// ==== tb/priority_interrupt_controller_tb.sv ====
/*
 * Random and corner tests of the interrupt controller.
 * Assumes package, design and pin source model compiled first.
 */
`timescale 1ns/1ns
module priority_interrupt_controller_tb;
	// ****************************************
	// Signals
	// ****************************************
	logic                     ref_clk, reset_n, trig0, trig1, go0, go1;
	logic [7:0]               en_a, en_b;  // Enable registers
	irq_ctrl_pkg::prio_regs_s prio;        // Priority registers
	logic [12:0]              src;         // Peripheral flags by source
	logic                     pin0_n, pin1_n, ser_rx, taken, ret, idle, pd;
	logic                     req, wake, f0, f1;
	logic [15:0]              vec;
	logic [1:0]               lvl;
	logic [3:0]               act;
	int                       n_fail = 0;
	int                       checks = 0;
	int                       w, w2;

	ext_pin_source src0_u (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
		.i_edge_mode(trig0), .i_hold(go0), .o_pin_n(pin0_n));
	ext_pin_source src1_u (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
		.i_edge_mode(trig1), .i_hold(go1), .o_pin_n(pin1_n));
	priority_interrupt_controller dut_u (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
		.i_irq_enable_reg_a(en_a), .i_irq_enable_reg_b(en_b), .i_prio(prio),
		.i_ext0_trigger_select(trig0), .i_ext1_trigger_select(trig1),
		.i_ext0_request_pin_n(pin0_n), .i_ext1_request_pin_n(pin1_n),
		.i_timer_zero_overflow_flag(src[1]), .i_timer_one_overflow_flag(src[3]),
		.i_serial_tx_done_flag(src[4] & !ser_rx), .i_serial_rx_done_flag(src[4] & ser_rx),
		.i_brownout_flag(src[5]), .i_bus_attention_flag(src[6]), .i_keypad_flag(src[7]),
		.i_comparator_two_flag(src[8]), .i_watchdog_overflow_flag(src[9]),
		.i_converter_done_flag(src[10]), .i_comparator_one_flag(src[11]),
		.i_bus_timeout_flag(src[12]), .i_irq_taken(taken), .i_irq_return(ret),
		.i_idle_mode(idle), .i_power_down_mode(pd), .o_irq_request(req),
		.o_vector_addr(vec), .o_irq_level(lvl), .o_active_levels(act), .o_wake(wake),
		.o_ext0_request_flag(f0), .o_ext1_request_flag(f1));

	// 20 MHz clock
	always #25 ref_clk = !ref_clk;

	// Level of a source, high bit over low bit
	function automatic logic [1:0] lvf(int i);
		logic [7:0] h, l;
		h = irq_ctrl_pkg::SRC_IN_REG_B[i] ? prio.prio_high_reg_b : prio.prio_high_reg_a;
		l = irq_ctrl_pkg::SRC_IN_REG_B[i] ? prio.prio_low_reg_b : prio.prio_low_reg_a;
		return {h[irq_ctrl_pkg::SRC_BIT[i]], l[irq_ctrl_pkg::SRC_BIT[i]]};
	endfunction

	// Own enable and global enable of a source
	function automatic logic enf(int i);
		logic [7:0] r;
		r = irq_ctrl_pkg::SRC_IN_REG_B[i] ? en_b : en_a;
		return en_a[7] && r[irq_ctrl_pkg::SRC_BIT[i]];
	endfunction

	// Vectors eight bytes apart, two unused slots
	function automatic logic [15:0] vecf(int i);
		return 16'(3 + 8 * (i < 9 ? i : (i < 12 ? i + 1 : i + 2)));
	endfunction

	// Winner above a level floor, -1 if none
	function automatic int winf(int floor);
		int b;
		int rk [13] = '{1, 4, 7, 10, 12, 2, 5, 8, 11, 3, 6, 9, 13};
		b = -1;
		for (int i = 0; i < 13; i++)
			if (src[i] && enf(i) && int'(lvf(i)) > floor && (b < 0 || lvf(i) > lvf(b)
				|| (lvf(i) == lvf(b) && rk[i] < rk[b])))
				b = i;
		return b;
	endfunction

	// Compare seen against expected
	task automatic chk(string name, logic [15:0] got, logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Let n edges pass, then sample at the falling edge
	task automatic settle(int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	// One-cycle take or return strobe
	task automatic strobe(logic is_ret);
		@(posedge ref_clk);
		{ret, taken} <= {is_ret, !is_ret};
		@(posedge ref_clk);
		{ret, taken} <= 2'b00;
		@(negedge ref_clk);
	endtask

	// Counts and verdict
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		ref_clk = 1'b0;
		reset_n = 1'b0;
		{trig0, trig1, go0, go1, ser_rx, taken, ret, idle, pd, src, prio, en_a, en_b} = '0;
		void'($urandom(61478));
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (24)
		begin
			@(posedge ref_clk);
			src <= 13'($urandom) & 13'h1FFA;
			prio <= $urandom;
			en_a <= 8'($urandom) | 8'h80;
			en_b <= 8'($urandom);
			ser_rx <= 1'($urandom);
			settle(1);
			w = winf(-1);
			chk("request", 16'(req), 16'(w >= 0));
			if (w >= 0)
			begin
				chk("vector", vec, vecf(w));
				chk("level", 16'(lvl), 16'(lvf(w)));
				strobe(1'b0);
				chk("active", 16'(act), 16'(4'h1 << lvf(w)));
				settle(0);
				w2 = winf(int'(lvf(w)));
				chk("preempt", 16'(req), 16'(w2 >= 0));
				if (w2 >= 0)
					chk("preempt vector", vec, vecf(w2));
				strobe(1'b1);
				chk("returned", 16'(act), 16'h0);
			end
			@(posedge ref_clk) src <= '0;
		end
		$display("test arbitration done");
		@(posedge ref_clk);
		src <= 13'h1FFA;
		en_a <= 8'h7F;
		en_b <= 8'hFF;
		settle(2);
		chk("masked", 16'(req), 16'h0);
		@(posedge ref_clk);
		{en_a, pd, src} <= {8'hFF, 1'b1, 13'h105A};
		settle(2);
		chk("no wake", 16'(wake), 16'h0);
		@(posedge ref_clk) {pd, idle} <= 2'b01;
		settle(2);
		chk("idle wake", 16'(wake), 16'h1);
		@(posedge ref_clk) {pd, idle, src} <= {2'b10, 13'h0080};
		settle(2);
		chk("keypad wake", 16'(wake), 16'h1);
		@(posedge ref_clk);
		{trig0, go0, src, prio} <= {1'h1, 1'h1, 13'h0000, 32'h0000_0000};
		@(posedge ref_clk) go0 <= 1'b0;
		w = 0;
		while (f0 !== 1'b1 && w < 40)
		begin
			settle(0);
			w++;
		end
		chk("edge flag", 16'(f0), 16'h1);
		settle(2);
		chk("ext0 vector", vec, 16'h0003);
		chk("ext wake", 16'(wake), 16'h1);
		strobe(1'b0);
		chk("edge clear", 16'(f0), 16'h0);
		strobe(1'b1);
		$display("test wake and edge done");
		@(posedge ref_clk);
		{pd, go1} <= 2'b01;
		settle(9);
		chk("level flag", 16'(f1), 16'h1);
		chk("ext1 vector", vec, 16'h0013);
		strobe(1'b0);
		strobe(1'b1);
		settle(2);
		chk("re-request", {15'h0, req}, 16'h1);
		@(posedge ref_clk) go1 <= 1'b0;
		settle(9);
		chk("level drop", 16'({f1, req}), 16'h0);
		$display("test level done");
		tally_and_finish();
	end

	// Hang guard
	initial
	begin
		#(50 * 6000);
		n_fail++;
		tally_and_finish();
	end
endmodule
